// ### hdl/ssr_pkg.sv
// status reporting constants, register map and carrier types
// Operation
// - status registers sixteen bits, bit 15 zero
// - write sets exactly the written bits
// - query returns weighted sum of set bits
// - condition bits follow live conditions
// - positive and negative filters select edges
// - selected transition sets sticky event bit
// - event read clears; clear-status clears all
// - after preset only positive transitions recorded
// - service enable selects requesting byte bits
// - service enable reads back last write; bits 0, 1 and 6 read as zero
// - status byte query returns set bits
// - request raises line and request flag
// - request needs enable and none pending
// - pending until controller reads status byte
// - one request flag, all bits shown
// - controller serial-polls when request line true
// - serial poll clears request flag and request line, no other bits
// - bit six shows the latched request flag
// - status byte query leaves contents unchanged
// - status byte bit assignment as listed
// - preset clears enables, positive filters 32767
package ssr_pkg;
    localparam int unsigned REG_W = 16;
    localparam logic [15:0] REG_MASK = 16'h7fff;
    localparam logic [15:0] PTR_PRESET = 16'h7fff;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam int unsigned GROUPS = 2;
    localparam int unsigned GRP_OPER = 0;
    localparam int unsigned GRP_QUES = 1;
    // status byte bit positions
    localparam int unsigned SB_ERRQ = 2;
    localparam int unsigned SB_QUES = 3;
    localparam int unsigned SB_MAV = 4;
    localparam int unsigned SB_ESB = 5;
    localparam int unsigned SB_RQS = 6;
    localparam int unsigned SB_OPER = 7;
    localparam logic [7:0] SRE_MASK = 8'hbc;
    // byte addresses
    localparam logic [7:0] A_OPER_COND = 8'h00;
    localparam logic [7:0] A_OPER_EVT = 8'h04;
    localparam logic [7:0] A_OPER_ENA = 8'h08;
    localparam logic [7:0] A_OPER_PTR = 8'h0c;
    localparam logic [7:0] A_OPER_NTR = 8'h10;
    localparam logic [7:0] A_QUES_COND = 8'h20;
    localparam logic [7:0] A_QUES_EVT = 8'h24;
    localparam logic [7:0] A_QUES_ENA = 8'h28;
    localparam logic [7:0] A_QUES_PTR = 8'h2c;
    localparam logic [7:0] A_QUES_NTR = 8'h30;
    localparam logic [7:0] A_STB = 8'h40;
    localparam logic [7:0] A_SRE = 8'h44;
    localparam logic [7:0] A_SPOLL = 8'h48;
    localparam logic [7:0] A_CMD = 8'h4c;
    localparam int unsigned CMD_CLS = 0;
    localparam int unsigned CMD_PRESET = 1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam int unsigned AW = 8;

    typedef struct packed {
        logic [15:0] ena;
        logic [15:0] ptr;
        logic [15:0] ntr;
    } ssr_cfg_t;

    typedef struct packed {
        logic wr_ena;
        logic wr_ptr;
        logic wr_ntr;
        logic rd_evt;
        logic cls;
        logic preset;
        logic [15:0] wdata;
    } ssr_grp_ctl_t;
endpackage

// ### hdl/ssr_group.sv
// one status group: condition, filters, sticky event, enable, summary
`timescale 1ns/1ps
module ssr_group
    import ssr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] cond_in,
    input wire ssr_pkg::ssr_grp_ctl_t ctl,
    output logic [15:0] cond,
    output logic [15:0] evt,
    output ssr_pkg::ssr_cfg_t cfg,
    output logic summary
);
    logic [15:0] cond_prev;
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] hit;
    logic [15:0] evt_kept;
    logic [15:0] next_evt;

    assign cond = cond_in & REG_MASK;
    assign rise = cond & ~cond_prev & cfg.ptr;
    assign fall = ~cond & cond_prev & cfg.ntr;
    assign hit = rise | fall;
    // read-clear and clear-status lose to a same-cycle new event
    assign evt_kept = (ctl.rd_evt || ctl.cls) ? ZERO16 : evt;
    assign next_evt = (evt_kept | hit) & REG_MASK;
    assign summary = |(evt & cfg.ena);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cond_prev <= ZERO16;
            evt <= ZERO16;
        end else begin
            cond_prev <= cond;
            evt <= next_evt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || ctl.preset) begin
            cfg.ena <= ZERO16;
            cfg.ptr <= PTR_PRESET;
            cfg.ntr <= ZERO16;
        end else begin
            if (ctl.wr_ena) cfg.ena <= ctl.wdata & REG_MASK;
            if (ctl.wr_ptr) cfg.ptr <= ctl.wdata & REG_MASK;
            if (ctl.wr_ntr) cfg.ntr <= ctl.wdata & REG_MASK;
        end
    end
endmodule // ssr_group

// ### hdl/ssr_sbyte.sv
// status byte, service request enable, request line and pending flag
`timescale 1ns/1ps
module ssr_sbyte
    import ssr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] sum_in,
    input wire logic sre_wr,
    input wire logic [7:0] sre_wdata,
    input wire logic stb_read,
    input wire logic spoll,
    output logic [7:0] sre,
    output logic [7:0] stb,
    output logic srq,
    output logic rqs
);
    logic [7:0] sbits;
    logic mss;
    logic start;

    assign sbits = sum_in & SRE_MASK;
    assign mss = |(sbits & sre);
    assign start = mss && !srq;
    // bit 6 shows the request flag; other bits live
    always_comb begin
        stb = sbits;
        stb[SB_RQS] = rqs;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sre <= ZERO8;
        end else if (sre_wr) begin
            sre <= sre_wdata & SRE_MASK;
        end
    end

    // a poll or read in the cycle a request starts does not clear it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            srq <= 1'b0;
            rqs <= 1'b0;
        end else if (start) begin
            srq <= 1'b1;
            rqs <= 1'b1;
        end else begin
            if (stb_read || spoll) srq <= 1'b0;
            if (spoll) rqs <= 1'b0;
        end
    end
endmodule // ssr_sbyte

// ### hdl/ssr_top.sv
// status reporting block with axi4-lite register access
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
module ssr_top
    import ssr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ssr_pkg::AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ssr_pkg::AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] oper_cond_in,
    input wire logic [15:0] ques_cond_in,
    input wire logic err_queue_nonempty,
    input wire logic msg_avail,
    input wire logic std_event_summary,
    output logic srq_out
);
    // write channel capture: address and data may come in either order
    logic aw_held;
    logic w_held;
    logic [AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic wr_low2;
    logic [15:0] wval;
    logic wr_ok;

    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign wr_low2 = w_strb[0] && w_strb[1];
    assign wval = w_data[15:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // one cycle ready pulses; never accept a second beat while one held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= s_axi_awvalid && !aw_held && !s_axi_awready;
            s_axi_wready <= s_axi_wvalid && !w_held && !s_axi_wready;
        end
    end

    // write decode
    logic is_oper_ena, is_oper_ptr, is_oper_ntr;
    logic is_ques_ena, is_ques_ptr, is_ques_ntr;
    logic is_sre, is_spoll_w, is_cmd, is_ro_w;
    assign is_oper_ena = aw_addr == A_OPER_ENA;
    assign is_oper_ptr = aw_addr == A_OPER_PTR;
    assign is_oper_ntr = aw_addr == A_OPER_NTR;
    assign is_ques_ena = aw_addr == A_QUES_ENA;
    assign is_ques_ptr = aw_addr == A_QUES_PTR;
    assign is_ques_ntr = aw_addr == A_QUES_NTR;
    assign is_sre = aw_addr == A_SRE;
    assign is_cmd = aw_addr == A_CMD;
    assign is_spoll_w = aw_addr == A_SPOLL;
    assign is_ro_w = aw_addr == A_OPER_COND || aw_addr == A_OPER_EVT
        || aw_addr == A_QUES_COND || aw_addr == A_QUES_EVT
        || aw_addr == A_STB || is_spoll_w;
    // writes missing either low byte strobe are dropped but still answered
    assign wr_ok = is_oper_ena || is_oper_ptr || is_oper_ntr
        || is_ques_ena || is_ques_ptr || is_ques_ntr || is_sre || is_cmd;

    logic do_wr;
    logic cmd_cls;
    logic cmd_preset;
    assign do_wr = wr_go && wr_low2;
    assign cmd_cls = do_wr && is_cmd && wval[CMD_CLS];
    assign cmd_preset = do_wr && is_cmd && wval[CMD_PRESET];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_ok || is_ro_w) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel
    logic rd_go;
    logic [AW-1:0] ra;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign ra = s_axi_araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready
                && !s_axi_rvalid;
        end
    end

    // status groups
    ssr_grp_ctl_t gctl [GROUPS];
    logic [15:0] gcond [GROUPS];
    logic [15:0] gevt [GROUPS];
    ssr_cfg_t gcfg [GROUPS];
    logic [GROUPS-1:0] gsum;
    logic [15:0] gin [GROUPS];
    logic [AW-1:0] gbase [GROUPS];
    assign gin[GRP_OPER] = oper_cond_in;
    assign gin[GRP_QUES] = ques_cond_in;
    assign gbase[GRP_OPER] = A_OPER_COND;
    assign gbase[GRP_QUES] = A_QUES_COND;

    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : g_grp
            logic [AW-1:0] off_ena, off_ptr, off_ntr, off_evt;
            assign off_ena = gbase[g] + (A_OPER_ENA - A_OPER_COND);
            assign off_ptr = gbase[g] + (A_OPER_PTR - A_OPER_COND);
            assign off_ntr = gbase[g] + (A_OPER_NTR - A_OPER_COND);
            assign off_evt = gbase[g] + (A_OPER_EVT - A_OPER_COND);
            assign gctl[g].wr_ena = do_wr && aw_addr == off_ena;
            assign gctl[g].wr_ptr = do_wr && aw_addr == off_ptr;
            assign gctl[g].wr_ntr = do_wr && aw_addr == off_ntr;
            assign gctl[g].rd_evt = rd_go && ra == off_evt;
            assign gctl[g].cls = cmd_cls;
            assign gctl[g].preset = cmd_preset;
            assign gctl[g].wdata = wval;
            ssr_group u_grp (
                .aclk(aclk),
                .aresetn(aresetn),
                .cond_in(gin[g]),
                .ctl(gctl[g]),
                .cond(gcond[g]),
                .evt(gevt[g]),
                .cfg(gcfg[g]),
                .summary(gsum[g])
            );
        end
    endgenerate

    // status byte
    logic [7:0] sum_in;
    logic [7:0] sre;
    logic [7:0] stb;
    logic srq;
    logic rqs;
    logic stb_read;
    logic spoll;
    assign sum_in = {gsum[GRP_OPER], 1'b0, std_event_summary, msg_avail,
        gsum[GRP_QUES], err_queue_nonempty, 2'b00};
    assign stb_read = rd_go && ra == A_STB;
    assign spoll = rd_go && ra == A_SPOLL;

    ssr_sbyte u_sb (
        .aclk(aclk),
        .aresetn(aresetn),
        .sum_in(sum_in),
        .sre_wr(do_wr && is_sre),
        .sre_wdata(wval[7:0]),
        .stb_read(stb_read),
        .spoll(spoll),
        .sre(sre),
        .stb(stb),
        .srq(srq),
        .rqs(rqs)
    );

    // read data mux; values captured before read side effects land
    logic [31:0] rmux;
    logic rhit;
    always_comb begin
        rmux = '0;
        rhit = 1'b1;
        unique case (ra)
            A_OPER_COND: rmux[15:0] = gcond[GRP_OPER];
            A_OPER_EVT: rmux[15:0] = gevt[GRP_OPER];
            A_OPER_ENA: rmux[15:0] = gcfg[GRP_OPER].ena;
            A_OPER_PTR: rmux[15:0] = gcfg[GRP_OPER].ptr;
            A_OPER_NTR: rmux[15:0] = gcfg[GRP_OPER].ntr;
            A_QUES_COND: rmux[15:0] = gcond[GRP_QUES];
            A_QUES_EVT: rmux[15:0] = gevt[GRP_QUES];
            A_QUES_ENA: rmux[15:0] = gcfg[GRP_QUES].ena;
            A_QUES_PTR: rmux[15:0] = gcfg[GRP_QUES].ptr;
            A_QUES_NTR: rmux[15:0] = gcfg[GRP_QUES].ntr;
            A_STB, A_SPOLL: rmux[7:0] = stb;
            A_SRE: rmux[7:0] = sre;
            A_CMD: rmux = '0;
            default: rhit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rmux;
            s_axi_rresp <= rhit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) srq_out <= 1'b0;
        else srq_out <= srq;
    end
endmodule // ssr_top

// ### dv/ssr_monitor.sv
// checker bound to the status reporting top
`timescale 1ns/1ps
module ssr_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ssr_pkg::AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic srq_out
);
    import ssr_pkg::*;
    logic [2:0] since_rd;
    logic ar_ok;
    assign ar_ok = s_axi_arvalid && s_axi_arready;
    // request line may only drop shortly after a status byte read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            since_rd <= 3'h7;
        end else if (ar_ok && (s_axi_araddr == A_STB ||
                s_axi_araddr == A_SPOLL)) begin
            since_rd <= 3'h0;
        end else if (since_rd != 3'h7) begin
            since_rd <= since_rd + 3'h1;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    read_lat_a: assert property (ar_ok |=> s_axi_rvalid)
        else $error("read data late");
    ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready too long");
    r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid not dropped");
    b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid not dropped");
    unmapped_rd_a: assert property (ar_ok && s_axi_araddr == 8'h14 |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read answered");
    top_zero_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0)
        else $error("high read bits set");
    stb_low_a: assert property (
        ar_ok && s_axi_araddr == A_STB |=> s_axi_rdata[1:0] == 2'b00)
        else $error("status byte low bits set");
    srq_hold_a: assert property (
        $fell(srq_out) |-> since_rd <= 3'h3)
        else $error("request dropped without read");
endmodule // ssr_monitor

bind ssr_top ssr_monitor u_ssr_monitor (.*);

// ### dv/ssr_ctl_model.sv
// bus controller model: axi4-lite master for queries and polls
`timescale 1ns/1ps
module ssr_ctl_model (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    output logic s_axi_bready,
    input wire logic s_axi_bvalid,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    output logic s_axi_rready,
    input wire logic s_axi_rvalid
);
    import ssr_pkg::*;
    logic aw_done;
    logic w_done;
    initial begin
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            aw_done = aw_done | s_axi_awready;
            w_done = w_done | s_axi_wready;
            if (aw_done)
                s_axi_awvalid <= 1'b0;
            if (w_done)
                s_axi_wvalid <= 1'b0;
        end
        // released lines must not look like a held payload
        s_axi_awaddr <= ~a;
        s_axi_wdata <= ~d;
        do
            @(posedge aclk);
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge aclk);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do
            @(posedge aclk);
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic poll();
        rd(A_SPOLL);
    endtask
endmodule // ssr_ctl_model

// ### dv/tb.sv
// self-checking bench for the status reporting block
`timescale 1ns/1ps
module tb;
    import ssr_pkg::*;
    localparam logic [7:0] A_NONE = 8'h14;
    localparam logic [7:0] CFG_A [6] = '{A_OPER_ENA, A_OPER_PTR,
        A_OPER_NTR, A_QUES_ENA, A_QUES_PTR, A_QUES_NTR};
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, srq_out;
    logic err_queue_nonempty, msg_avail, std_event_summary;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] oper_cond_in, ques_cond_in, v;
    logic [33:0] exp_q[$];
    logic [33:0] msk_q[$];
    logic [33:0] e, m;
    int error_cnt, comparisons, cycles, n;

    ssr_top u_ssr_top (.s_axi_awprot(3'h0), .s_axi_wstrb(4'hf),
        .s_axi_arprot(3'h0), .*);
    ssr_ctl_model u_ssr_ctl_model (.*);

    always #12.5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    always @(posedge aclk) begin
        if ((s_axi_bvalid && s_axi_bready) ||
                (s_axi_rvalid && s_axi_rready)) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            if (s_axi_bvalid)
                check("bresp", {s_axi_bresp, 32'h0} & m, e & m);
            else
                check("rdata", {s_axi_rresp, s_axi_rdata} & m, e & m);
        end
    end
    task automatic check(input string nm, input logic [33:0] seen,
            input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
            input logic [1:0] r = RESP_OKAY);
        exp_q.push_back({r, 32'h0});
        msk_q.push_back({34{1'b1}});
        u_ssr_ctl_model.wr(a, {16'h0, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] r = RESP_OKAY, input logic [31:0] k = '1);
        exp_q.push_back({r, d});
        msk_q.push_back({2'b11, k});
        u_ssr_ctl_model.rd(a);
    endtask
    task automatic cfg_chk();
        for (int g = 0; g < 6; g++)
            rd(CFG_A[g], (g % 3 == 1) ? 32'h7fff : 32'h0);
    endtask
    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        oper_cond_in = 16'h0;
        ques_cond_in = 16'h0;
        err_queue_nonempty = 1'b0;
        msg_avail = 1'b0;
        std_event_summary = 1'b0;
        void'($urandom(32'hdacb));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cfg_chk();
        rd(A_SRE, 32'h0);
        for (int i = 0; i < 12; i++) begin
            v = 16'($urandom());
            wr(CFG_A[i % 6], v);
            rd(CFG_A[i % 6], {16'h0, v & REG_MASK});
            wr(A_SRE, v);
            rd(A_SRE, {24'h0, v[7:0] & SRE_MASK});
        end
        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom());
            oper_cond_in <= v;
            ques_cond_in <= ~v;
            @(posedge aclk);
            rd(A_OPER_COND, {16'h0, v & REG_MASK});
            rd(A_QUES_COND, {16'h0, ~v & REG_MASK});
        end
        oper_cond_in <= 16'h0;
        ques_cond_in <= 16'h0;
        wr(A_OPER_PTR, 16'h0005);
        wr(A_OPER_NTR, 16'h0006);
        wr(A_CMD, 16'h0001);
        rd(A_OPER_EVT, 32'h0);
        oper_cond_in <= 16'h0007;
        repeat (3) @(posedge aclk);
        rd(A_OPER_EVT, 32'h5);
        rd(A_OPER_EVT, 32'h0);
        oper_cond_in <= 16'h0;
        repeat (3) @(posedge aclk);
        rd(A_OPER_EVT, 32'h6);
        wr(A_OPER_COND, 16'h1234);
        rd(A_OPER_COND, 32'h0);
        wr(A_NONE, 16'h1, RESP_SLVERR);
        rd(A_NONE, 32'h0, RESP_SLVERR);
        rd(A_CMD, 32'h0);
        wr(A_SRE, 16'h0);
        wr(A_CMD, 16'h0002);
        wr(A_CMD, 16'h0001);
        cfg_chk();
        // stale request state from the random phase is flushed
        exp_q.push_back({RESP_OKAY, 32'h0});
        msk_q.push_back({2'b11, 32'h0});
        u_ssr_ctl_model.poll();
        // inputs stay still while the masks are set up
        wr(A_OPER_ENA, 16'h0008);
        wr(A_QUES_ENA, 16'h4000);
        err_queue_nonempty <= 1'b1;
        msg_avail <= 1'b1;
        std_event_summary <= 1'b1;
        oper_cond_in <= 16'h0008;
        ques_cond_in <= 16'h4000;
        repeat (6) @(posedge aclk);
        check("srq_out", {33'h0, srq_out}, 34'h0);
        wr(A_SRE, 16'h00bc);
        n = 0;
        while (srq_out !== 1'b1 && n < 20) begin
            @(posedge aclk);
            n++;
        end
        check("srq_out", {33'h0, srq_out}, 34'h1);
        rd(A_STB, 32'hfc);
        rd(A_STB, 32'hfc);
        wr(A_SRE, 16'h0);
        rd(A_SPOLL, 32'hfc, RESP_OKAY, 32'hffffffbf);
        rd(A_STB, 32'hbc);
        repeat (4) @(posedge aclk);
        check("srq_out", {33'h0, srq_out}, 34'h0);
        rd(A_QUES_EVT, 32'h4000);
        rd(A_QUES_EVT, 32'h0);
        rd(A_STB, 32'hb4);
        wr(A_SPOLL, 16'h0);
        summarize();
    end
endmodule // tb
